// ===== hw/sdc_pkg.sv
package sdc_pkg;

  // Clock and times
  localparam int CLK_HZ            = 25_000_000;
  localparam int CLK_PER_MS        = CLK_HZ / 1000;
  localparam int REFRESH_TIME_MS   = 250;
  localparam int READOUT_TIMEOUT_S = 60;
  localparam int LOCKOUT_TIME_S    = 60;
  localparam int READOUT_TIMEOUT_MS = READOUT_TIMEOUT_S * 1000;
  localparam int LOCKOUT_TIME_MS    = LOCKOUT_TIME_S * 1000;

  // Sizes
  localparam int LOG_DEPTH  = 124;
  localparam int PW_MAX     = 8;
  localparam int SLOT_LAST  = 4;
  localparam int SNAP_WORDS = 8;

  // Register offsets (byte addresses); the snapshot page is address bits 7:5
  localparam logic [7:0] REG_CMD       = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_LOG_INDEX = 8'h08;
  localparam logic [7:0] REG_LOG_CODE  = 8'h0C;
  localparam logic [7:0] REG_LOG_TIME  = 8'h10;
  localparam logic [7:0] REG_LOG_COUNT = 8'h14;
  localparam logic [2:0] REG_SNAP_PAGE = 3'h1;

  // Command register fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_ARG_LSB  = 4;
  localparam int CMD_CONT_BIT = 7;

  // Opcodes; readout kinds equal the low three opcode bits
  localparam logic [3:0] OP_ANALOG   = 4'h1;
  localparam logic [3:0] OP_FILTER   = 4'h2;
  localparam logic [3:0] OP_IO       = 4'h3;
  localparam logic [3:0] OP_MEASURE  = 4'h4;
  localparam logic [3:0] OP_SUPPLY   = 4'h5;
  localparam logic [3:0] OP_QUALITY  = 4'h6;
  localparam logic [3:0] OP_THERMAL  = 4'h7;
  localparam logic [3:0] OP_PASSWORD = 4'h8;
  localparam logic [3:0] OP_STORE    = 4'h9;
  localparam logic [3:0] OP_RESTART  = 4'hA;
  localparam logic [3:0] OP_RESTORE  = 4'hB;
  localparam logic [2:0] ARG_FACTORY = 3'h7;

  // Status register fields
  localparam int ST_READOUT  = 0;
  localparam int ST_CONT     = 1;
  localparam int ST_PW_ENTRY = 2;
  localparam int ST_LOCKED   = 3;
  localparam int ST_PW_ON    = 4;
  localparam int ST_CMD_ERR  = 5;
  localparam int ST_SLOT_LSB = 8;
  localparam int ST_KIND_LSB = 12;

  // Characters
  localparam logic [7:0] CH_ESC   = 8'h1B;
  localparam logic [7:0] CH_ENTER = 8'h0D;
  localparam logic [7:0] CH_STAR  = 8'h2A;

  // Preset password, first character in the low byte
  localparam logic [63:0] PW_PRESET     = 64'h0000_0000_4147_4557;
  localparam logic [3:0]  PW_PRESET_LEN = 4'h4;

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_READOUT,
    MODE_PW_OLD,
    MODE_PW_NEW
  } sdc_mode_t;

  typedef struct packed {
    logic [31:0]      velocity;
    logic [31:0]      length;
    logic [31:0]      frequency;
    logic [7:0]       rate;
    logic [7:0]       current_pct;
    logic [15:0]      load;
    logic [15:0]      periods;
    logic [15:0]      exposure;
    logic [15:0]      lamp;
    logic [15:0]      fifo_level;
    logic             load_ok;
    logic             card_fitted;
    logic             moving;
    logic             over_exp;
    logic             under_exp;
    logic             trig_one;
    logic             trigger_output_two;
    logic             motion;
    logic             idle_state_output;
    logic             fault;
    logic             condition;
    logic [3:0][31:0] aux;
  } sdc_meas_t;

  typedef struct packed {
    logic       load;
    logic       factory;
    logic       store;
    logic       restart;
    logic [2:0] slot;
  } sdc_param_t;

endpackage

// ===== hw/sdc_service_cmd.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// R1: A running readout refreshes its value snapshot every 250 ms.
// R2: A readout ends on escape, else on its own after 60 s.
// R3: Continuous flag C suppresses the readout timeout; only escape ends it.
// R4: Normal data output is suspended while any readout runs.
// R5: Analog readout load reads zero without a valid load or analog card.
// R6: Analog readout holds velocity, rate, current percent and load.
// R7: I/O readout holds velocity, length, rate and six output line states.
// R8: Measurement readout holds ten measurement values including fifo level.
// R9: Quality shows rate while moving, else lamp times exposure.
// R10: Error log keeps 124 entries; a full log overwrites its oldest.
// R11: Severe errors are logged with time stamp; log readable, never cleared (reset zeroes the log count and write pointer).
// R12: Store needs the password; a command changes the password.
// R13: Password up to eight characters, echoed as stars, compared caseless.
// R14: Empty new password confirmed by enter disables protection.
// R15: Escape during password entry abandons it without change.
// R16: Three wrong passwords report illegal use and lock commands 60 s.
// R17: Restart reinitialises and reloads the last saved parameters.
// R18: Restore loads slot 0 to 4, discarding unsaved changes.
// R19: Restore without slot number loads slot 0.
// R20: Restart and power-up reload the set last restored or stored.
// R21: Restore f loads write-protected factory defaults, not remembered.
// R22: After a readout ends, normal data output resumes unchanged.
module sdc_service_cmd #(
  parameter int CLK_PER_MS = sdc_pkg::CLK_PER_MS,
  parameter int REFRESH_MS = sdc_pkg::REFRESH_TIME_MS,
  parameter int TIMEOUT_MS = sdc_pkg::READOUT_TIMEOUT_MS,
  parameter int LOCK_MS    = sdc_pkg::LOCKOUT_TIME_MS,
  parameter int LOG_DEPTH  = sdc_pkg::LOG_DEPTH
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output      logic [31:0]       reg_rdata,
  // Host character stream
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_char,
  output      logic              tx_valid,
  output      logic [7:0]        tx_char,
  // Measurement values
  input  wire sdc_pkg::sdc_meas_t meas,
  // Error events
  input  wire logic              err_valid,
  input  wire logic              err_severe,
  input  wire logic [15:0]       err_code,
  input  wire logic [31:0]       now_stamp,
  // Parameter storage
  input  wire logic [2:0]        boot_slot,
  output      sdc_pkg::sdc_param_t param,
  output      logic [2:0]        last_slot,
  // Output control
  output      logic              data_out_en,
  output      logic              readout_tick,
  output      logic              illegal_use
);

  localparam int LW = $clog2(LOG_DEPTH);

  generate
    if (CLK_PER_MS < 2 || CLK_PER_MS > 65535 || REFRESH_MS < 1 || TIMEOUT_MS < 1
        || LOCK_MS < 1 || LOG_DEPTH < 2) begin : g_bad_param
      $error("sdc_service_cmd: parameter out of range");
    end
  endgenerate

  typedef struct packed {
    sdc_pkg::sdc_mode_t mode;
    logic [2:0]         kind;
    logic               cont;
    logic [15:0]        ms_div;
    logic [31:0]        refresh_cnt;
    logic [31:0]        timeout_cnt;
    logic [31:0]        lock_cnt;
    logic               locked;
    logic [1:0]         fails;
    logic               goal_store;
    logic [2:0]         store_slot;
    logic [63:0]        pw_buf;
    logic [3:0]         pw_buf_len;
    logic [63:0]        pw;
    logic [3:0]         pw_len;
    logic               pw_on;
    logic [7:0][31:0]   snap;
    logic               tick;
    sdc_pkg::sdc_param_t prm;
    logic [2:0]         last_slot;
    logic               booted;
    logic               cmd_err;
    logic               illegal;
    logic               tx_valid;
    logic [7:0]         tx_char;
    logic [LW-1:0]      log_wptr;
    logic [LW:0]        log_cnt;
    logic [LW-1:0]      log_idx;
    logic [31:0]        rdata;
  } sdc_state_t;

  sdc_state_t s;
  sdc_state_t next_s;

  // Log memory has no reset; entries are only meaningful below log_cnt
  logic [15:0] log_code [LOG_DEPTH];
  logic [31:0] log_time [LOG_DEPTH];

  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction

  function automatic logic [LW-1:0] wrap_add(input logic [LW-1:0] a, input logic [LW-1:0] b);
    logic [LW:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum >= (LW+1)'(LOG_DEPTH)) sum = sum - (LW+1)'(LOG_DEPTH);
    return sum[LW-1:0];
  endfunction

  function automatic logic [7:0][31:0] build_snap(input logic [2:0] kind,
                                                   input sdc_pkg::sdc_meas_t m);
    logic [7:0][31:0] w;
    w = '0;
    case ({1'b0, kind})
      sdc_pkg::OP_ANALOG: begin
        w[0] = m.velocity; // R6
        w[1] = {24'h0, m.rate};
        w[2] = {24'h0, m.current_pct};
        w[3] = (m.load_ok && m.card_fitted) ? {16'h0, m.load} : 32'h0; // R5
      end
      sdc_pkg::OP_FILTER: begin
        w[0] = m.frequency;
        w[1] = m.velocity;
        w[2] = {24'h0, m.rate};
        w[6:3] = m.aux;
      end
      sdc_pkg::OP_IO: begin
        w[0] = m.velocity; // R7
        w[1] = m.length;
        w[2] = {24'h0, m.rate};
        w[3] = {26'h0, m.trig_one, m.trigger_output_two, m.motion,
                m.idle_state_output, m.fault, m.condition};
      end
      sdc_pkg::OP_MEASURE: begin
        w[0] = m.frequency; // R8
        w[1] = m.velocity;
        w[2] = m.length;
        w[3] = {24'h0, m.rate};
        w[4] = {16'h0, m.periods};
        w[5] = {16'h0, m.exposure};
        w[6] = {16'h0, m.lamp};
        w[7] = {14'h0, m.over_exp, m.under_exp, m.fifo_level};
      end
      sdc_pkg::OP_QUALITY: begin
        // R9
        w[0] = m.moving ? {24'h0, m.rate} : {16'h0, m.lamp} * {16'h0, m.exposure};
        w[1] = {31'h0, m.moving};
      end
      default: w[3:0] = m.aux;
    endcase
    return w;
  endfunction

  logic          ms_tick;
  logic          cmd_wr;
  logic [3:0]    op;
  logic [2:0]    arg;
  logic          rx_esc;
  logic          pw_match;
  logic [LW-1:0] log_rd;

  assign ms_tick  = (s.ms_div == 16'(CLK_PER_MS - 1));
  assign cmd_wr   = reg_wr && (reg_addr == sdc_pkg::REG_CMD);
  assign op       = reg_wdata[sdc_pkg::CMD_OP_LSB +: 4];
  assign arg      = reg_wdata[sdc_pkg::CMD_ARG_LSB +: 3];
  assign rx_esc   = rx_valid && (rx_char == sdc_pkg::CH_ESC);
  assign pw_match = (s.pw_buf == s.pw) && (s.pw_buf_len == s.pw_len); // R13
  // Index 0 is the oldest entry once the log has wrapped
  assign log_rd   = wrap_add((s.log_cnt == (LW+1)'(LOG_DEPTH)) ? s.log_wptr : '0, s.log_idx);

  always_comb begin
    next_s         = s;
    next_s.tick    = 1'b0;
    next_s.prm     = '0;
    next_s.illegal = 1'b0;
    next_s.tx_valid = 1'b0;
    next_s.ms_div  = ms_tick ? 16'h0 : s.ms_div + 16'h1;

    // Power-up load of the remembered set
    if (!s.booted) begin
      next_s.booted    = 1'b1;
      next_s.prm.load  = 1'b1; // R20
      next_s.prm.slot  = (boot_slot > 3'(sdc_pkg::SLOT_LAST)) ? 3'h0 : boot_slot;
      next_s.last_slot = next_s.prm.slot;
    end

    if (s.locked && ms_tick) begin
      next_s.lock_cnt = s.lock_cnt + 32'h1;
      if (s.lock_cnt == 32'(LOCK_MS - 1)) next_s.locked = 1'b0; // R16
    end

    unique case (s.mode)
      sdc_pkg::MODE_IDLE: begin
        if (cmd_wr && s.locked) begin
          next_s.cmd_err = 1'b1; // R16
        end else if (cmd_wr) begin
          next_s.cmd_err = 1'b0;
          case (op)
            sdc_pkg::OP_ANALOG, sdc_pkg::OP_FILTER, sdc_pkg::OP_IO, sdc_pkg::OP_MEASURE,
            sdc_pkg::OP_SUPPLY, sdc_pkg::OP_QUALITY, sdc_pkg::OP_THERMAL: begin
              next_s.mode        = sdc_pkg::MODE_READOUT;
              next_s.kind        = op[2:0];
              next_s.cont        = reg_wdata[sdc_pkg::CMD_CONT_BIT]; // R3
              next_s.refresh_cnt = '0;
              next_s.timeout_cnt = '0;
              next_s.ms_div      = '0;
              next_s.snap        = build_snap(op[2:0], meas);
              next_s.tick        = 1'b1;
            end
            sdc_pkg::OP_PASSWORD: begin
              next_s.goal_store = 1'b0;
              next_s.mode       = s.pw_on ? sdc_pkg::MODE_PW_OLD : sdc_pkg::MODE_PW_NEW; // R12
              next_s.pw_buf     = '0;
              next_s.pw_buf_len = '0;
            end
            sdc_pkg::OP_STORE: begin
              if (arg > 3'(sdc_pkg::SLOT_LAST)) begin
                next_s.cmd_err = 1'b1;
              end else if (s.pw_on) begin
                next_s.goal_store = 1'b1; // R12
                next_s.store_slot = arg;
                next_s.mode       = sdc_pkg::MODE_PW_OLD;
                next_s.pw_buf     = '0;
                next_s.pw_buf_len = '0;
              end else begin
                next_s.prm.store = 1'b1;
                next_s.prm.slot  = arg;
                next_s.last_slot = arg; // R20
              end
            end
            sdc_pkg::OP_RESTART: begin
              next_s.prm.restart = 1'b1; // R17
              next_s.prm.load    = 1'b1;
              next_s.prm.slot    = s.last_slot; // R20
            end
            sdc_pkg::OP_RESTORE: begin
              if (arg == sdc_pkg::ARG_FACTORY) begin
                next_s.prm.load    = 1'b1; // R21
                next_s.prm.factory = 1'b1;
              end else if (arg <= 3'(sdc_pkg::SLOT_LAST)) begin
                next_s.prm.load  = 1'b1; // R18 R19
                next_s.prm.slot  = arg;
                next_s.last_slot = arg; // R20
              end else begin
                next_s.cmd_err = 1'b1;
              end
            end
            default: next_s.cmd_err = 1'b1;
          endcase
        end
      end
      sdc_pkg::MODE_READOUT: begin
        if (cmd_wr) next_s.cmd_err = 1'b1;
        if (rx_esc) begin
          next_s.mode = sdc_pkg::MODE_IDLE; // R2 R22
        end else if (ms_tick) begin
          next_s.refresh_cnt = s.refresh_cnt + 32'h1;
          next_s.timeout_cnt = s.timeout_cnt + 32'h1;
          if (s.refresh_cnt == 32'(REFRESH_MS - 1)) begin
            next_s.refresh_cnt = '0; // R1
            next_s.snap        = build_snap(s.kind, meas);
            next_s.tick        = 1'b1;
          end
          if (!s.cont && s.timeout_cnt == 32'(TIMEOUT_MS - 1)) begin
            next_s.mode = sdc_pkg::MODE_IDLE; // R2 R3
          end
        end
      end
      sdc_pkg::MODE_PW_OLD, sdc_pkg::MODE_PW_NEW: begin
        if (cmd_wr) next_s.cmd_err = 1'b1;
        if (rx_esc) begin
          next_s.mode = sdc_pkg::MODE_IDLE; // R15
        end else if (rx_valid && rx_char == sdc_pkg::CH_ENTER) begin
          next_s.mode       = sdc_pkg::MODE_IDLE;
          next_s.pw_buf     = '0;
          next_s.pw_buf_len = '0;
          if (s.mode == sdc_pkg::MODE_PW_NEW) begin
            next_s.pw     = s.pw_buf;
            next_s.pw_len = s.pw_buf_len;
            next_s.pw_on  = (s.pw_buf_len != 4'h0); // R14
          end else if (pw_match) begin
            next_s.fails = '0;
            if (s.goal_store) begin
              next_s.prm.store = 1'b1; // R12
              next_s.prm.slot  = s.store_slot;
              next_s.last_slot = s.store_slot;
            end else begin
              next_s.mode = sdc_pkg::MODE_PW_NEW;
            end
          end else if (s.fails == 2'h2) begin
            next_s.fails    = '0; // R16
            next_s.locked   = 1'b1;
            next_s.lock_cnt = '0;
            next_s.illegal  = 1'b1;
          end else begin
            next_s.fails = s.fails + 2'h1;
          end
        end else if (rx_valid) begin
          if (s.pw_buf_len < 4'(sdc_pkg::PW_MAX)) begin
            next_s.pw_buf[s.pw_buf_len[2:0]*8 +: 8] = upcase(rx_char); // R13
            next_s.pw_buf_len = s.pw_buf_len + 4'h1;
            next_s.tx_valid   = 1'b1;
            next_s.tx_char    = sdc_pkg::CH_STAR;
          end
        end
      end
    endcase

    // Severe errors only; no command clears the log, only reset zeroes its count
    if (err_valid && err_severe) begin
      next_s.log_wptr = wrap_add(s.log_wptr, LW'(1)); // R10 R11
      if (s.log_cnt != (LW+1)'(LOG_DEPTH)) next_s.log_cnt = s.log_cnt + 1'b1;
    end

    if (reg_wr && reg_addr == sdc_pkg::REG_LOG_INDEX) begin
      next_s.log_idx = (reg_wdata[LW-1:0] >= LW'(LOG_DEPTH)) ? '0 : reg_wdata[LW-1:0];
    end

    next_s.rdata = '0;
    if (reg_rd) begin
      if (reg_addr[7:5] == sdc_pkg::REG_SNAP_PAGE) begin
        next_s.rdata = s.snap[reg_addr[4:2]];
      end else begin
        case (reg_addr)
          sdc_pkg::REG_STATUS: begin
            next_s.rdata[sdc_pkg::ST_READOUT]  = (s.mode == sdc_pkg::MODE_READOUT);
            next_s.rdata[sdc_pkg::ST_CONT]     = s.cont;
            next_s.rdata[sdc_pkg::ST_PW_ENTRY] = (s.mode == sdc_pkg::MODE_PW_OLD)
                                                 || (s.mode == sdc_pkg::MODE_PW_NEW);
            next_s.rdata[sdc_pkg::ST_LOCKED]   = s.locked;
            next_s.rdata[sdc_pkg::ST_PW_ON]    = s.pw_on;
            next_s.rdata[sdc_pkg::ST_CMD_ERR]  = s.cmd_err;
            next_s.rdata[sdc_pkg::ST_SLOT_LSB +: 3] = s.last_slot;
            next_s.rdata[sdc_pkg::ST_KIND_LSB +: 3] = s.kind;
          end
          sdc_pkg::REG_LOG_INDEX: next_s.rdata[LW-1:0] = s.log_idx;
          sdc_pkg::REG_LOG_CODE:  next_s.rdata[15:0]   = log_code[log_rd]; // R11
          sdc_pkg::REG_LOG_TIME:  next_s.rdata         = log_time[log_rd];
          sdc_pkg::REG_LOG_COUNT: next_s.rdata[LW:0]   = s.log_cnt;
          default:                next_s.rdata         = '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s        <= '0;
      s.mode   <= sdc_pkg::MODE_IDLE;
      s.pw     <= sdc_pkg::PW_PRESET;
      s.pw_len <= sdc_pkg::PW_PRESET_LEN;
      s.pw_on  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (err_valid && err_severe) begin
      log_code[s.log_wptr] <= err_code; // R10 R11
      log_time[s.log_wptr] <= now_stamp;
    end
  end

  assign reg_rdata    = s.rdata;
  assign tx_valid     = s.tx_valid;
  assign tx_char      = s.tx_char;
  assign param        = s.prm;
  assign last_slot    = s.last_slot;
  assign data_out_en  = (s.mode != sdc_pkg::MODE_READOUT); // R4 R22
  assign readout_tick = s.tick;
  assign illegal_use  = s.illegal;

  // Checking helpers
  logic [31:0] tick_gap;
  logic        run_seen;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_gap <= '0;
      run_seen <= 1'b0;
    end else begin
      tick_gap <= readout_tick ? 32'h0 : tick_gap + 32'h1;
      run_seen <= (s.mode == sdc_pkg::MODE_READOUT) && (run_seen || readout_tick);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_refresh_period: assert property (readout_tick && run_seen |-> // R1
    tick_gap == 32'(REFRESH_MS * CLK_PER_MS - 1))
    else $error("readout refresh period wrong");
  chk_esc_ends_run: assert property ((s.mode == sdc_pkg::MODE_READOUT) && rx_esc // R2
    |=> data_out_en && !readout_tick)
    else $error("escape did not end readout");
  chk_cont_keeps_run: assert property ((s.mode == sdc_pkg::MODE_READOUT) && s.cont // R3
    && !rx_esc |=> s.mode == sdc_pkg::MODE_READOUT)
    else $error("continuous readout ended without escape");
  chk_output_suspend: assert property (readout_tick |-> !data_out_en) // R4
    else $error("data output active during readout");
  chk_load_zero: assert property (readout_tick && s.kind == sdc_pkg::OP_ANALOG[2:0] // R5
    && !($past(meas.load_ok) && $past(meas.card_fitted)) |-> s.snap[3] == 32'h0)
    else $error("load not zero without load or card");
  chk_quality_value: assert property (readout_tick && s.kind == sdc_pkg::OP_QUALITY[2:0] // R9
    && !$past(meas.moving)
    |-> s.snap[0] == {16'h0, $past(meas.lamp)} * {16'h0, $past(meas.exposure)})
    else $error("standstill quality wrong");
  chk_log_bound: assert property ((s.log_cnt <= (LW+1)'(LOG_DEPTH)) and // R10
    (err_valid && err_severe && s.log_cnt == (LW+1)'(LOG_DEPTH)
    |=> s.log_cnt == $past(s.log_cnt)))
    else $error("log count beyond depth");
  chk_star_echo: assert property ((s.mode == sdc_pkg::MODE_PW_OLD) && rx_valid && !rx_esc // R13
    && rx_char != sdc_pkg::CH_ENTER && s.pw_buf_len == 4'h0
    |=> tx_valid && tx_char == sdc_pkg::CH_STAR)
    else $error("password character not echoed as star");
  chk_lock_refuse: assert property (s.locked && cmd_wr |=> param == '0 && !readout_tick) // R16
    else $error("command accepted while locked");
  chk_restore_slot: assert property ((s.mode == sdc_pkg::MODE_IDLE) && !s.locked && s.booted // R19
    && cmd_wr && op == sdc_pkg::OP_RESTORE && arg == 3'h0
    |=> param.load && param.slot == 3'h0 && last_slot == 3'h0)
    else $error("restore without slot not slot zero");
  chk_factory_unsaved: assert property (param.factory |-> last_slot == $past(last_slot)) // R21
    else $error("factory load changed remembered slot");

  cov_timeout_end: cover property ((s.mode == sdc_pkg::MODE_READOUT) && !s.cont
    ##1 s.mode == sdc_pkg::MODE_IDLE && !$past(rx_esc));
  cov_lockout: cover property (illegal_use);
  cov_pw_off: cover property ($fell(s.pw_on));
  cov_log_full: cover property (s.log_cnt == (LW+1)'(LOG_DEPTH));

endmodule // sdc_service_cmd

// ===== tb/sdc_host_model.sv
`timescale 1ns/1ps
module sdc_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Characters to the block
  output      logic       rx_valid,
  output      logic [7:0] rx_char
);
  initial begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
  end
  // Released line shows the inverse, never a stale char
  task send(input logic [7:0] c);
    rx_valid <= 1'b1;
    rx_char  <= c;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_char  <= ~c;
    #1;
  endtask
endmodule // sdc_host_model

// ===== tb/sdc_service_cmd_bench.sv
`timescale 1ns/1ps
module sdc_service_cmd_bench;
  logic               sys_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [7:0]         reg_addr = 8'h00;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               err_valid = 1'b0;
  logic [15:0]        err_code = 16'h0;
  logic [31:0]        ts = 32'h0;
  logic               sev = 1'b1;
  logic [2:0]         boot = 3'h3;
  sdc_pkg::sdc_meas_t meas = '0;
  sdc_pkg::sdc_param_t param;
  logic [31:0]        reg_rdata, d;
  logic [7:0]         rx_char, tx_char;
  logic               rx_valid, tx_valid, data_out_en, readout_tick, illegal_use;
  logic [2:0]         last_slot, s_slot, l_slot;
  int error_cnt = 0, comparisons = 0, n_store = 0, n_load = 0, n_fact = 0, n_star = 0, n_ill = 0;

  always #20 sys_clk = ~sys_clk;

  // Short counts keep the run small
  sdc_service_cmd #(.CLK_PER_MS(4), .REFRESH_MS(3), .TIMEOUT_MS(20), .LOCK_MS(10)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_char(rx_char), .tx_valid(tx_valid), .tx_char(tx_char), .meas(meas),
    .err_valid(err_valid), .err_severe(sev), .err_code(err_code), .now_stamp(ts),
    .boot_slot(boot), .param(param), .last_slot(last_slot), .data_out_en(data_out_en),
    .readout_tick(readout_tick), .illegal_use(illegal_use));
  sdc_host_model host (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_char(rx_char));

  always @(posedge sys_clk) begin
    if (param.store) begin
      n_store++;
      s_slot = param.slot;
    end
    if (param.load) begin
      n_load++;
      l_slot = param.slot;
    end
    if (param.factory) n_fact++;
    if (tx_valid && tx_char === 8'h2A) n_star++;
    if (illegal_use) n_ill++;
  end

  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task esc;
    host.send(8'h1B);
    cyc(1);
  endtask
  task ro(input logic [31:0] c, input logic [7:0] a);
    wr(8'h00, c);
    rd(a);
    esc();
  endtask
  task typ(input string s);
    foreach (s[i]) host.send(s[i]);
    host.send(8'h0D);
    cyc(2);
  endtask
  task final_report;
    $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    cyc(8000);
    error_cnt++;
    final_report;
  end

  initial begin
    meas.velocity = 32'h0000_1234;
    meas.lamp = 16'h0012;
    meas.exposure = 16'h0034;
    meas.load = 16'h0099;
    meas.card_fitted = 1'b1;
    meas.trig_one = 1'b1;
    meas.idle_state_output = 1'b1;
    meas.condition = 1'b1;
    meas.under_exp = 1'b1;
    meas.fifo_level = 16'h0077;
    cyc(12);
    rst_b <= 1'b1;
    cyc(3);
    chk("boot slot", {n_load[28:0], l_slot}, 32'h0000_000B);
    chk("output on", data_out_en, 32'h1);
    wr(8'h00, 32'h0000_0001);
    chk("first tick", readout_tick, 32'h1);
    chk("output off", data_out_en, 32'h0);
    cyc(12);
    chk("tick period", readout_tick, 32'h1);
    rd(8'h20);
    chk("velocity", d, 32'h0000_1234);
    rd(8'h2C);
    chk("load", d, 32'h0);
    cyc(50);
    chk("running", data_out_en, 32'h0);
    cyc(30);
    chk("timeout", data_out_en, 32'h1);
    wr(8'h00, 32'h0000_0083);
    cyc(100);
    chk("no timeout", data_out_en, 32'h0);
    rd(8'h2C);
    chk("io lines", d, 32'h0000_0025);
    esc();
    chk("escape", data_out_en, 32'h1);
    wr(8'h00, 32'h0000_0006);
    rd(8'h20);
    chk("quality", d, 32'h0000_03A8);
    esc();
    wr(8'h00, 32'h0000_0004);
    rd(8'h3C);
    chk("fifo word", d, 32'h0001_0077);
    esc();
    meas.aux[0] <= 32'h0000_0A5C;
    meas.aux[1] <= 32'h0000_0B6D;
    meas.moving <= 1'b1;
    meas.rate <= 8'h21;
    meas.load_ok <= 1'b1;
    ro(32'h0000_0002, 8'h2C);
    chk("filter aux", d, 32'h0000_0A5C);
    ro(32'h0000_0005, 8'h24);
    chk("supply aux", d, 32'h0000_0B6D);
    ro(32'h0000_0007, 8'h20);
    chk("thermal aux", d, 32'h0000_0A5C);
    ro(32'h0000_0006, 8'h20);
    chk("moving quality", d, 32'h0000_0021);
    ro(32'h0000_0001, 8'h2C);
    chk("load fitted", d, 32'h0000_0099);
    wr(8'h00, 32'h0000_0029);
    host.send("W");
    esc();
    chk("abandon", n_store, 32'h0);
    wr(8'h00, 32'h0000_0029);
    typ("wega");
    chk("store", {n_store[28:0], s_slot}, 32'h0000_000A);
    chk("stars", n_star, 32'h5);
    repeat (3) begin
      wr(8'h00, 32'h0000_0029);
      typ("bad");
    end
    chk("illegal use", n_ill, 32'h1);
    wr(8'h00, 32'h0000_000B);
    rd(8'h04);
    chk("locked", d[5:3], 32'h7);
    cyc(50);
    wr(8'h00, 32'h0000_000B);
    cyc(1);
    chk("restore 0", {l_slot, last_slot}, 32'h0);
    wr(8'h00, 32'h0000_007B);
    cyc(1);
    chk("factory", {n_fact[28:0], last_slot}, 32'h8);
    wr(8'h00, 32'h0000_004B);
    cyc(1);
    chk("restore 4", l_slot, 32'h4);
    for (int i = 0; i < 127; i++) begin
      err_code <= 16'(i);
      ts <= 32'(i + 100);
      err_valid <= 1'b1;
      sev <= (i < 126);
      @(posedge sys_clk);
    end
    err_valid <= 1'b0;
    cyc(2);
    rd(8'h14);
    chk("log count", d, 32'd124);
    wr(8'h08, 32'h0);
    rd(8'h0C);
    chk("oldest code", d, 32'h2);
    rd(8'h10);
    chk("stamp", d, 32'd102);
    rd(8'h18);
    chk("unmapped", d, 32'h0);
    rst_b <= 1'b0;
    boot <= 3'h6;
    cyc(2);
    rst_b <= 1'b1;
    cyc(2);
    chk("reboot slot", {l_slot, last_slot}, 32'h0);
    wr(8'h00, 32'h0000_0008);
    typ("Wega");
    typ("");
    rd(8'h04);
    chk("protection off", d[4], 32'h0);
    wr(8'h00, 32'h0000_0019);
    cyc(1);
    chk("open store", s_slot, 32'h1);
    wr(8'h00, 32'h0000_000A);
    chk("restart", param, 32'h0000_0049);
    final_report;
  end
endmodule // sdc_service_cmd_bench
